// file: shared/cbs_pkg.sv
// Constants, field layouts and carrier types for the configuration bus access and security block
package cbs_pkg;
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int OSC_NOMINAL_HZ = 96_000_000;
  localparam int I2C_MAX_HZ = 1_000_000;
  localparam int I2C_SAMPLES_PER_BIT = CLK_HZ / I2C_MAX_HZ;
  localparam int NVM_OP_US = 100;
  localparam int NVM_OP_CYCLES = NVM_OP_US * (CLK_HZ / 1_000_000);
  localparam int NVM_LINES = 6;

  // Bus addresses
  localparam logic [6:0] TEST_BUS_ADDR = 7'h0A;

  // Serial bus register map (byte pointer)
  localparam logic [7:0] REG_NVM_CMD = 8'h00;
  localparam logic [7:0] REG_PWD_LO = 8'h01;
  localparam logic [7:0] REG_PWD_HI = 8'h02;
  localparam logic [7:0] REG_CFG_BASE = 8'h08;
  localparam logic [7:0] REG_TELEM_BASE = 8'h88;

  // Nonvolatile command field
  localparam int NVM_OP_LSB = 6;
  localparam int NVM_READ_OK_BIT = 5;
  localparam int NVM_WR_FAIL_BIT = 4;
  localparam logic [1:0] NVM_OP_IDLE = 2'h0;
  localparam logic [1:0] NVM_OP_WRITE = 2'h1;
  localparam logic [1:0] NVM_OP_READ = 2'h2;

  // Access modes
  localparam logic [1:0] ACC_OPEN = 2'h0;
  localparam logic [1:0] ACC_PASSWORD = 2'h1;
  localparam logic [1:0] ACC_LOCKED = 2'h2;
  localparam logic [1:0] ACC_TELEM = 2'h3;

  // Configuration bytes
  localparam int CFG_ADDR = 0;
  localparam int CFG_PROT = 1;
  localparam int CFG_PWD_LO = 2;
  localparam int CFG_PWD_HI = 3;
  localparam int CFG_FREQ0 = 4;
  localparam int CFG_STEP = 6;
  localparam int ADDR_PIN_BIT = 7;
  localparam int PROT_HW_EN_BIT = 0;
  localparam int PROT_MODE_LSB = 1;
  localparam int PROT_WR_BIT = 3;
  localparam int PROT_RD_BIT = 4;
  localparam int PROT_PEC_BIT = 5;
  localparam logic [63:0] CFG_RESET = 64'h0000_0404_0000_0040;

  // Register offsets on the host bus
  localparam logic [7:0] AXI_CTRL = 8'h00;
  localparam logic [7:0] AXI_TELEM0 = 8'h04;
  localparam logic [7:0] AXI_TELEM1 = 8'h08;
  localparam logic [7:0] AXI_STATUS = 8'h0C;
  localparam logic [7:0] AXI_VID = 8'h10;
  localparam int CTRL_RELOAD_BIT = 0;
  localparam int ST_PEC_ERR_BIT = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Voltage ID
  localparam logic [7:0] VID_SHUTDOWN = 8'h00;
  localparam logic [7:0] CRC8_POLY = 8'h07;

  typedef struct packed {
    logic valid;
    logic loop;
    logic [7:0] code;
  } cbs_vid_t;

  typedef struct packed {
    logic [8:0] target_5mv;
    logic regulator_disable;
  } cbs_target_t;
endpackage

// file: rtl/cbs_config_port.sv
// Serial configuration port with access protection, nonvolatile programming and voltage-ID decode
module cbs_config_port #(
  parameter int ADDR_W = 8,
  parameter int NVM_LINES = cbs_pkg::NVM_LINES,
  parameter int NVM_OP_CYCLES = cbs_pkg::NVM_OP_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_protect_pin,
  input wire cbs_pkg::cbs_vid_t vid_in,
  output cbs_pkg::cbs_target_t [1:0] vid_target,
  output logic [1:0] switch_clk,
  output logic regulation_allowed
);
  generate
    if (ADDR_W < 5 || NVM_LINES < 1 || NVM_LINES > 8 || NVM_OP_CYCLES < 1)
      $error("cbs_config_port: unsupported parameter value");
    if (cbs_pkg::I2C_SAMPLES_PER_BIT < 8)
      $error("cbs_config_port: clock too slow for serial bus rate");
  endgenerate

  typedef enum logic [3:0] {
    LD_SAMPLE = 4'b0001,
    LD_TEST = 4'b0010,
    LD_LOAD = 4'b0100,
    LD_DONE = 4'b1000
  } cbs_load_t;

  typedef enum logic [5:0] {
    I_IDLE = 6'b000001,
    I_ADDR = 6'b000010,
    I_ACK = 6'b000100,
    I_WBYTE = 6'b001000,
    I_RBYTE = 6'b010000,
    I_RACK = 6'b100000
  } cbs_ser_t;

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ((r << 1) ^ cbs_pkg::CRC8_POLY) : (r << 1);
    return r;
  endfunction

  function automatic logic [7:0] crc64(input logic [63:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
      r = crc8(r, v[8*i +: 8]);
    return r;
  endfunction

  // Working configuration and nonvolatile store
  logic [7:0] cfg [8];
  logic [63:0] nvm_data [NVM_LINES];
  logic [7:0] nvm_crc [NVM_LINES];
  logic [NVM_LINES-1:0] nvm_used;
  logic [63:0] cfg_image;
  logic [31:0] telem [2];
  cbs_load_t ld_state;
  logic test_mode, crc_ok, strap_bit, unlocked, pec_err;
  logic [7:0] pw_entry;
  logic [1:0] nvm_op;
  logic [2:0] nvm_line;
  logic nvm_read_ok, nvm_wr_fail;
  int unsigned nvm_cnt;

  always_comb
  begin
    for (int i = 0; i < 8; i++)
      cfg_image[8*i +: 8] = cfg[i];
  end

  wire [1:0] acc_mode = cfg[cbs_pkg::CFG_PROT][cbs_pkg::PROT_MODE_LSB +: 2];
  wire pec_en = cfg[cbs_pkg::CFG_PROT][cbs_pkg::PROT_PEC_BIT];
  wire [15:0] password = {cfg[cbs_pkg::CFG_PWD_HI], cfg[cbs_pkg::CFG_PWD_LO]};
  wire ld_done = ld_state == LD_DONE;
  wire [6:0] cfg_addr = cfg[cbs_pkg::CFG_ADDR][6:0];
  wire addr_from_pin = cfg[cbs_pkg::CFG_ADDR][cbs_pkg::ADDR_PIN_BIT];
  wire [6:0] my_addr = test_mode ? cbs_pkg::TEST_BUS_ADDR :
    (addr_from_pin ? {cfg_addr[6:1], strap_bit} : cfg_addr);
  wire hw_protected = cfg[cbs_pkg::CFG_PROT][cbs_pkg::PROT_HW_EN_BIT] & ld_done & ~test_mode
    & ~addr_protect_pin;
  wire nvm_busy = nvm_op != cbs_pkg::NVM_OP_IDLE;

  // Serial bus sampling and framing
  logic scl_p, sda_p;
  cbs_ser_t ist;
  logic [3:0] bcnt;
  logic [7:0] shreg, tx, ptr, crc, pend, pend_a, pend_crc;
  logic rw, ptr_set, mack, pend_v;
  logic [1:0] rd_idx;

  wire scl_rise = scl_in & ~scl_p;
  wire scl_fall = ~scl_in & scl_p;
  wire start_c = scl_in & scl_p & sda_p & ~sda_in;
  wire stop_c = scl_in & scl_p & ~sda_p & sda_in;
  wire byte_done = scl_fall & (bcnt == 4'd8);

  // Access decisions
  wire is_telem_r = ptr[7:3] == cbs_pkg::REG_TELEM_BASE[7:3];
  wire is_cfg_r = ptr[7:3] == cbs_pkg::REG_CFG_BASE[7:3];
  wire pw_rd_block = acc_mode == cbs_pkg::ACC_PASSWORD & cfg[cbs_pkg::CFG_PROT][cbs_pkg::PROT_RD_BIT] & ~unlocked;
  wire pw_wr_block = acc_mode == cbs_pkg::ACC_PASSWORD & cfg[cbs_pkg::CFG_PROT][cbs_pkg::PROT_WR_BIT] & ~unlocked;
  wire rd_allowed = acc_mode != cbs_pkg::ACC_LOCKED & (acc_mode != cbs_pkg::ACC_TELEM | is_telem_r)
    & ~pw_rd_block;
  wire pwd_w = pend_a == cbs_pkg::REG_PWD_LO | pend_a == cbs_pkg::REG_PWD_HI;
  wire cfg_w = pend_a[7:3] == cbs_pkg::REG_CFG_BASE[7:3];
  wire wr_allowed = acc_mode != cbs_pkg::ACC_LOCKED & acc_mode != cbs_pkg::ACC_TELEM
    & (pwd_w | (~hw_protected & ~pw_wr_block));

  // Byte sent on a read
  logic [7:0] rd_data;
  always_comb
  begin
    rd_data = 8'h00;
    if (ptr == cbs_pkg::REG_NVM_CMD)
      rd_data = {nvm_op, nvm_read_ok, nvm_wr_fail, 1'b0, nvm_line};
    else if (is_cfg_r && ptr[2:1] != 2'b01)
      rd_data = cfg[ptr[2:0]];
    else if (is_telem_r)
      rd_data = telem[ptr[2]][8*ptr[1:0] +: 8];
  end
  wire pec_slot = pec_en & (rd_idx == 2'd1);
  wire [7:0] tx_byte = pec_slot ? crc : (rd_allowed ? rd_data : 8'hFF);

  // Commit of a received data byte; with checking, the last byte is the check byte
  wire pec_match = pend == pend_crc;
  wire commit = pend_v & ((ist == I_WBYTE & byte_done & ptr_set) | (stop_c & (~pec_en | pec_match)));
  wire do_write = commit & wr_allowed;
  wire cmd_w = do_write & pend_a == cbs_pkg::REG_NVM_CMD & ~nvm_busy;
  wire [1:0] cmd_op = pend[cbs_pkg::NVM_OP_LSB +: 2];
  wire cmd_ok = {1'b0, pend[2:0]} < 4'(NVM_LINES) && !nvm_used[pend[2:0]];

  always_ff @(posedge aclk)
  begin
    scl_p <= aresetn ? scl_in : 1'b1;
    sda_p <= aresetn ? sda_in : 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ist <= I_IDLE;
      bcnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      crc <= 8'h00;
      rw <= 1'b0;
      ptr_set <= 1'b0;
      mack <= 1'b0;
      rd_idx <= 2'd0;
      sda_oe <= 1'b0;
      pend <= 8'h00;
      pend_a <= 8'h00;
      pend_crc <= 8'h00;
      pend_v <= 1'b0;
    end
    else if (stop_c)
    begin
      ist <= I_IDLE;
      sda_oe <= 1'b0;
      pend_v <= 1'b0;
      crc <= 8'h00;
    end
    else if (start_c)
    begin
      ist <= I_ADDR;
      bcnt <= 4'h0;
      sda_oe <= 1'b0;
      rd_idx <= 2'd0;
    end
    else
    begin
      if (scl_rise && (ist == I_ADDR || ist == I_WBYTE))
      begin
        shreg <= {shreg[6:0], sda_in};
        bcnt <= bcnt + 4'd1;
      end
      if (scl_rise && ist == I_RACK)
        mack <= ~sda_in;
      unique case (ist)
        I_IDLE: ;
        I_ADDR:
          if (byte_done)
          begin
            crc <= crc8(crc, shreg);
            rw <= shreg[0];
            if (!shreg[0])
              ptr_set <= 1'b0;
            sda_oe <= shreg[7:1] == my_addr;
            ist <= (shreg[7:1] == my_addr) ? I_ACK : I_IDLE;
          end
        I_WBYTE:
          if (byte_done)
          begin
            crc <= crc8(crc, shreg);
            sda_oe <= 1'b1;
            ist <= I_ACK;
            if (!ptr_set)
            begin
              ptr <= shreg;
              ptr_set <= 1'b1;
            end
            else
            begin
              pend <= shreg;
              pend_a <= ptr;
              pend_crc <= crc;
              pend_v <= 1'b1;
              ptr <= ptr + 8'd1;
            end
          end
        I_ACK, I_RACK:
          if (scl_fall)
          begin
            bcnt <= 4'h0;
            sda_oe <= 1'b0;
            ist <= I_WBYTE;
            if (rw && (ist == I_ACK || mack))
            begin
              sda_oe <= ~tx_byte[7];
              tx <= {tx_byte[6:0], 1'b0};
              bcnt <= 4'd1;
              ist <= I_RBYTE;
              rd_idx <= (rd_idx == 2'd3) ? rd_idx : rd_idx + 2'd1;
              if (!pec_slot)
              begin
                crc <= crc8(crc, tx_byte);
                ptr <= ptr + 8'd1;
              end
            end
            else if (rw)
              ist <= I_IDLE;
          end
        I_RBYTE:
          if (scl_fall)
          begin
            if (bcnt == 4'd8)
            begin
              sda_oe <= 1'b0;
              ist <= I_RACK;
            end
            else
            begin
              sda_oe <= ~tx[7];
              tx <= {tx[6:0], 1'b0};
              bcnt <= bcnt + 4'd1;
            end
          end
      endcase
    end
  end

  // Protection state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      unlocked <= 1'b0;
      pw_entry <= 8'h00;
    end
    else if (do_write && pend_a == cbs_pkg::REG_PWD_LO)
      pw_entry <= pend;
    else if (do_write && pend_a == cbs_pkg::REG_PWD_HI)
      unlocked <= {pend, pw_entry} == password;
  end

  // Load sequence, configuration writes and nonvolatile engine
  logic found;
  logic [2:0] top_line;
  always_comb
  begin
    found = 1'b0;
    top_line = 3'd0;
    for (int i = 0; i < NVM_LINES; i++)
      if (nvm_used[i])
      begin
        found = 1'b1;
        top_line = 3'(i);
      end
  end
  wire reload_req;
  wire load_crc_ok = ~found || crc64(nvm_data[top_line]) == nvm_crc[top_line];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ld_state <= LD_SAMPLE;
      test_mode <= 1'b0;
      strap_bit <= 1'b0;
      crc_ok <= 1'b0;
    end
    else
      unique case (ld_state)
        LD_SAMPLE:
        begin
          test_mode <= addr_protect_pin;
          ld_state <= addr_protect_pin ? LD_TEST : LD_LOAD;
        end
        LD_TEST:
          if (!addr_protect_pin)
            ld_state <= LD_LOAD;
        LD_LOAD:
        begin
          strap_bit <= addr_protect_pin;
          crc_ok <= load_crc_ok;
          ld_state <= LD_DONE;
        end
        LD_DONE:
          if (reload_req)
            ld_state <= LD_LOAD;
      endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 8; i++)
        cfg[i] <= cbs_pkg::CFG_RESET[8*i +: 8];
    end
    else if (ld_state == LD_LOAD && found && load_crc_ok)
    begin
      for (int i = 0; i < 8; i++)
        cfg[i] <= nvm_data[top_line][8*i +: 8];
    end
    else if (do_write && cfg_w)
      cfg[pend_a[2:0]] <= pend;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      nvm_op <= cbs_pkg::NVM_OP_IDLE;
      nvm_line <= 3'd0;
      nvm_cnt <= 0;
      nvm_read_ok <= 1'b0;
      nvm_wr_fail <= 1'b0;
      nvm_used <= '0;
      for (int i = 0; i < NVM_LINES; i++)
      begin
        nvm_data[i] <= 64'h0;
        nvm_crc[i] <= 8'h00;
      end
    end
    else if (nvm_busy)
    begin
      nvm_cnt <= nvm_cnt + 1;
      if (nvm_cnt == NVM_OP_CYCLES - 1)
      begin
        nvm_op <= cbs_pkg::NVM_OP_IDLE;
        if (nvm_op == cbs_pkg::NVM_OP_WRITE)
        begin
          nvm_data[nvm_line] <= cfg_image;
          nvm_crc[nvm_line] <= crc64(cfg_image);
          nvm_used[nvm_line] <= 1'b1;
        end
        else
          nvm_read_ok <= nvm_used[nvm_line] && nvm_data[nvm_line] == cfg_image
            && nvm_crc[nvm_line] == crc64(nvm_data[nvm_line]);
      end
    end
    else if (cmd_w && cmd_op == cbs_pkg::NVM_OP_WRITE)
    begin
      nvm_line <= pend[2:0];
      nvm_wr_fail <= ~cmd_ok;
      nvm_op <= cmd_ok ? cbs_pkg::NVM_OP_WRITE : cbs_pkg::NVM_OP_IDLE;
      nvm_cnt <= 0;
    end
    else if (cmd_w && cmd_op == cbs_pkg::NVM_OP_READ && {1'b0, pend[2:0]} < 4'(NVM_LINES))
    begin
      nvm_line <= pend[2:0];
      nvm_read_ok <= 1'b0;
      nvm_op <= cbs_pkg::NVM_OP_READ;
      nvm_cnt <= 0;
    end
  end

  // Voltage-ID decode and switching clocks, one per loop
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_loop
      logic [7:0] div_cnt;
      wire step10 = cfg[cbs_pkg::CFG_STEP][g];
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          vid_target[g] <= '{target_5mv: 9'h000, regulator_disable: 1'b1};
        else if (vid_in.valid && vid_in.loop == 1'(g))
        begin
          vid_target[g].target_5mv <= step10 ? {vid_in.code, 1'b0} : {1'b0, vid_in.code};
          vid_target[g].regulator_disable <= vid_in.code == cbs_pkg::VID_SHUTDOWN;
        end
      end
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          div_cnt <= 8'h00;
          switch_clk[g] <= 1'b0;
        end
        else if (div_cnt >= cfg[cbs_pkg::CFG_FREQ0 + g])
        begin
          div_cnt <= 8'h00;
          switch_clk[g] <= ~switch_clk[g];
        end
        else
          div_cnt <= div_cnt + 8'h01;
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    sda_out <= 1'b0;
    regulation_allowed <= aresetn & ld_done & crc_ok;
  end

  // Host bus slave
  logic aw_held, w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire wr_now = aw_held & w_held & ~s_axi_bvalid;
  wire [7:0] wa = 8'(aw_addr);
  wire [7:0] ra = 8'(s_axi_araddr);
  wire wa_telem = wa == cbs_pkg::AXI_TELEM0 || wa == cbs_pkg::AXI_TELEM1;
  wire wa_ok = wa == cbs_pkg::AXI_CTRL || wa_telem || wa == cbs_pkg::AXI_STATUS;
  assign reload_req = wr_now & wa == cbs_pkg::AXI_CTRL & w_strb[0] & w_data[cbs_pkg::CTRL_RELOAD_BIT];
  wire pec_clr = wr_now & wa == cbs_pkg::AXI_STATUS & w_strb[0] & w_data[cbs_pkg::ST_PEC_ERR_BIT];
  wire [31:0] status_word = {16'h0, 8'(nvm_used), pec_err, nvm_read_ok, nvm_wr_fail, nvm_busy,
    unlocked, hw_protected, test_mode, crc_ok};
  wire [31:0] vid_word = {12'h0, vid_target[1], vid_target[0]};
  wire ra_ok = ra == cbs_pkg::AXI_CTRL || ra == cbs_pkg::AXI_TELEM0 || ra == cbs_pkg::AXI_TELEM1
    || ra == cbs_pkg::AXI_STATUS || ra == cbs_pkg::AXI_VID;
  wire [31:0] ra_data = ra == cbs_pkg::AXI_TELEM0 ? telem[0] : ra == cbs_pkg::AXI_TELEM1 ? telem[1]
    : ra == cbs_pkg::AXI_STATUS ? status_word : ra == cbs_pkg::AXI_VID ? vid_word : 32'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pec_err <= 1'b0;
    else if (stop_c && pend_v && pec_en && !pec_match)
      pec_err <= 1'b1;
    else if (pec_clr)
      pec_err <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cbs_pkg::RESP_OKAY;
      telem[0] <= 32'h0;
      telem[1] <= 32'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_now)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wa_ok ? cbs_pkg::RESP_OKAY : cbs_pkg::RESP_SLVERR;
        if (wa_telem)
          for (int b = 0; b < 4; b++)
            if (w_strb[b])
              telem[wa[3]][8*b +: 8] <= w_data[8*b +: 8];
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= cbs_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= ra_data;
      s_axi_rresp <= ra_ok ? cbs_pkg::RESP_OKAY : cbs_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// file: verification/cbs_config_port_monitor.sv
// Assertions on the configuration port's bus handshakes, decoder and start-up
module cbs_config_port_mon (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic scl_in,
  input wire logic addr_protect_pin,
  input wire cbs_pkg::cbs_vid_t vid_in,
  input wire cbs_pkg::cbs_target_t [1:0] vid_target,
  input wire logic regulation_allowed
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_busy;
    !s_axi_awready && !s_axi_wready;
  endsequence
  a_write_answer: assert property (s_wr_taken |=> s_wr_busy ##1 s_axi_bvalid)
    else $error("write response late");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  a_shutdown_loop0: assert property (vid_in.valid && !vid_in.loop && vid_in.code == cbs_pkg::VID_SHUTDOWN
    |=> vid_target[0].regulator_disable)
    else $error("shutdown code ignored");
  a_live_loop1: assert property (vid_in.valid && vid_in.loop && vid_in.code != cbs_pkg::VID_SHUTDOWN
    |=> !vid_target[1].regulator_disable)
    else $error("live code disabled loop");
  a_start_load: assert property ($rose(aresetn) && !addr_protect_pin |-> ##[1:4] regulation_allowed)
    else $error("regulation not allowed after load");
  a_test_wait: assert property (addr_protect_pin && !regulation_allowed |=> !regulation_allowed)
    else $error("load while pin high");
  // Data line may only move while the clock is low, else it fakes a start or stop
  a_sda_drain: assert property ($changed(sda_oe) |-> !scl_in && !sda_out)
    else $error("data line driven high");
endmodule

bind cbs_config_port cbs_config_port_mon u_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .sda_out, .sda_oe, .scl_in, .addr_protect_pin, .vid_in, .vid_target,
  .regulation_allowed);

// file: verification/cbs_i2c_host.sv
// Serial bus master model: start, byte writes with acknowledge check, stop
module cbs_i2c_host (
  input wire logic aclk,
  input wire logic sda_line,
  output logic scl = 1'b1,
  output logic sda_drv = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 13; // Bit of 52 cycles keeps the bus under 1MHz
  task automatic step(input logic c, input logic s);
    scl <= c;
    sda_drv <= s;
    repeat (Q) @(posedge aclk);
  endtask
  task automatic put(input logic [7:0] v, inout logic ok);
    logic [8:0] w;
    w = {v, 1'b1};
    for (int i = 8; i >= 0; i--)
    begin
      step(1'b0, sda_drv);
      step(1'b0, w[i]);
      step(1'b1, sda_drv);
      step(1'b1, sda_drv);
    end
    ok &= !sda_line;
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [15:0] pd, output logic ok);
    ok = 1'b1;
    step(1'b1, 1'b0);
    put({a, 1'b0}, ok);
    put(pd[15:8], ok);
    put(pd[7:0], ok);
    step(1'b0, sda_drv);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
endmodule

// file: verification/config_bus_access_security_tb.sv
// Bench: register bus, serial writes, locking, voltage-ID decode and test mode
module config_bus_access_security_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, addr_protect_pin, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, scl, sda_drv, ok;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic sda_out, sda_oe, regulation_allowed;
  logic [1:0] switch_clk;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  cbs_pkg::cbs_vid_t vid_in;
  cbs_pkg::cbs_target_t [1:0] vid_target;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  // Pull-up on the data line
  wire sda_line = sda_drv & ~sda_oe;
  cbs_config_port #(.NVM_OP_CYCLES(100)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe,
    .addr_protect_pin, .vid_in, .vid_target, .switch_clk, .regulation_allowed);
  cbs_i2c_host u_host (.aclk, .sda_line, .scl, .sda_drv);
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic t_clk(input int g, input int exp);
    logic p;
    int n;
    n = 0;
    p = switch_clk[g];
    while (switch_clk[g] == p) @(posedge aclk);
    p = switch_clk[g];
    while (switch_clk[g] == p)
    begin
      @(posedge aclk);
      n++;
    end
    check(32'(n), 32'(exp));
  endtask
  task automatic t_nvm();
    u_host.write_reg(7'h40, 16'h0D09, ok);
    t_clk(0, 5);
    t_clk(1, 10);
    u_host.write_reg(7'h40, 16'h0040, ok);
    axi_rd(cbs_pkg::AXI_STATUS);
    check(32'(d[4]), 32'h1);
    while (d[4]) axi_rd(cbs_pkg::AXI_STATUS);
    check(32'(d[15:4]), 32'h010);
    u_host.write_reg(7'h40, 16'h0080, ok);
    do axi_rd(cbs_pkg::AXI_STATUS); while (d[4]);
    check(32'(d[6]), 32'h1);
    u_host.write_reg(7'h40, 16'h0040, ok);
    axi_rd(cbs_pkg::AXI_STATUS);
    check(32'(d[5:4]), 32'h2);
    u_host.write_reg(7'h40, 16'h0901, ok);
    axi_rd(cbs_pkg::AXI_STATUS);
    check(32'(d[2]), 32'h1);
    addr_protect_pin <= 1'b1;
    axi_rd(cbs_pkg::AXI_STATUS);
    check(32'(d[2]), 32'h0);
    addr_protect_pin <= 1'b0;
    axi_wr(cbs_pkg::AXI_CTRL, 32'h1);
    axi_rd(cbs_pkg::AXI_STATUS);
    check(32'(d[2:0]), 32'h1);
    $display("nonvolatile test done");
  endtask
  task automatic send_vid(input logic lp, input logic [7:0] c, input logic [8:0] t, input logic dis);
    vid_in <= '{1'b1, lp, c};
    @(posedge aclk);
    vid_in.valid <= 1'b0;
    @(posedge aclk);
    check(32'(vid_target[lp]), {22'h0, t, dis});
  endtask
  task automatic reset_dut();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask
  task automatic t_regs();
    axi_rd(cbs_pkg::AXI_STATUS);
    check(32'(d[1:0]), 32'h1);
    check(32'(regulation_allowed), 32'h1);
    axi_rd(cbs_pkg::AXI_VID);
    check(d, 32'h0000_0401);
    axi_rd(8'h20);
    check({d[29:0], r}, 32'(cbs_pkg::RESP_SLVERR));
    axi_wr(cbs_pkg::AXI_VID, 32'h0);
    check(32'(r), 32'(cbs_pkg::RESP_SLVERR));
    axi_wr(cbs_pkg::AXI_TELEM1, 32'hA5C3_5A3C);
    axi_rd(cbs_pkg::AXI_TELEM1);
    check(d, 32'hA5C3_5A3C);
    $display("register test done");
  endtask
  task automatic t_vid();
    send_vid(1'b0, 8'h00, 9'h000, 1'b1);
    send_vid(1'b1, 8'h7F, 9'h07F, 1'b0);
    send_vid(1'b0, 8'hFF, 9'h0FF, 1'b0);
    $display("decoder test done");
  endtask
  task automatic t_serial();
    u_host.write_reg(7'h41, 16'h0E02, ok);
    check(32'(ok), 32'h0);
    u_host.write_reg(7'h40, 16'h0E02, ok);
    check(32'(ok), 32'h1);
    send_vid(1'b1, 8'h30, 9'h060, 1'b0);
    send_vid(1'b0, 8'h30, 9'h030, 1'b0);
    // Locked mode, then a step change that must be dropped
    u_host.write_reg(7'h40, 16'h0904, ok);
    u_host.write_reg(7'h40, 16'h0E00, ok);
    send_vid(1'b1, 8'h30, 9'h060, 1'b0);
    $display("serial test done");
  endtask
  task automatic t_test_mode();
    addr_protect_pin <= 1'b1;
    reset_dut();
    axi_rd(cbs_pkg::AXI_STATUS);
    check(32'(d[1]), 32'h1);
    check(32'(regulation_allowed), 32'h0);
    addr_protect_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    check(32'(regulation_allowed), 32'h1);
    $display("test mode test done");
  endtask
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      num_errors++;
      complete_run();
    end
  end
  initial
  begin
    {aresetn, addr_protect_pin, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    vid_in = '0;
    reset_dut();
    t_regs();
    t_vid();
    t_nvm();
    t_serial();
    t_test_mode();
    complete_run();
  end
endmodule
